//--- hdl/svm_bridge_regs.vh
// register offsets, field layouts and codes of the sbus to vme master window bridge
`ifndef SVM_BRIDGE_REGS_VH
`define SVM_BRIDGE_REGS_VH

// per-range register block: range index in addr[7:4], register in addr[3:0]
`define SVM_RANGE_SEL_HI     7
`define SVM_RANGE_SEL_LO     4
`define SVM_REG_SEL_HI       3
`define SVM_REG_SEL_LO       0
`define SVM_GLOBAL_BIT       8
`define SVM_REG_VME_BASE     4'h0
`define SVM_REG_SB_CODE      4'h1
`define SVM_REG_CAP          4'h2
`define SVM_REG_ENA          4'h3
`define SVM_REG_WIN_BASE     4'h4
`define SVM_REG_WIN_MASK     4'h5
// global registers (addr[8] set)
`define SVM_REG_BURST_LEN    4'h0
`define SVM_REG_READ_STOP    4'h1
`define SVM_REG_STATUS       4'h2

// compare code layout: slot [31:29], size exponent [28:24], base word [23:0]
`define SVM_CODE_SLOT_HI     31
`define SVM_CODE_SLOT_LO     29
`define SVM_CODE_EXP_HI      28
`define SVM_CODE_EXP_LO      24
`define SVM_CODE_BASE_HI     23
`define SVM_CODE_BASE_LO     0
`define SVM_CODE_BASE_SHIFT  4

// capability register: data width [2:0], address space [6:4]
`define SVM_CAP_DW_HI        2
`define SVM_CAP_DW_LO        0
`define SVM_CAP_AS_HI        6
`define SVM_CAP_AS_LO        4

// data width codes
`define SVM_DW_BYTE          3'h0
`define SVM_DW_HALFWORD      3'h1
`define SVM_DW_WORD          3'h2
`define SVM_DW_BLOCK         3'h3
`define SVM_DW_MBLOCK        3'h4
// address space codes
`define SVM_AS_SHORT         3'h0
`define SVM_AS_STANDARD      3'h1
`define SVM_AS_EXTENDED      3'h2
`define SVM_AS_64            3'h4

// access size on the sbus side
`define SVM_SZ_BYTE          2'h0
`define SVM_SZ_HALF          2'h1
`define SVM_SZ_WORD          2'h2

// burst and stop codes: bytes = 8 << code
`define SVM_BYTES_BASE       7'h08
`define SVM_RESET_CODE2      2'h0
`define SVM_EXP_MAX          5'h1c

// two-bit setting field and range enable bit in the write data
`define SVM_CODE2_HI         1
`define SVM_CODE2_LO         0
`define SVM_ENA_BIT          0
`endif

//--- hdl/svm_bridge.v
// sbus to vme master window bridge: sixteen ranges, decode, translation and settings
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "svm_bridge_regs.vh"

module svm_bridge #(
  parameter NRANGE = 16,
  parameter AW     = 32
) (
  // register bus
  input  wire          sys_clk,
  input  wire          nrst,
  input  wire          clk_en,
  input  wire [8:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  // sbus slave access request
  input  wire          sb_req,
  input  wire [2:0]    sb_slot,
  input  wire [AW-1:0] sb_addr,
  input  wire [1:0]    sb_size,
  input  wire          sb_write,
  // vme master cycle
  output reg           vme_start,
  output reg  [AW-1:0] vme_addr,
  output reg  [2:0]    vme_space,
  output reg  [1:0]    vme_size,
  output reg           vme_write,
  output reg           sb_reject,
  // sbus master settings
  output reg  [1:0]    burst_len_code,
  output reg  [6:0]    burst_len_bytes,
  output reg  [6:0]    read_stop_bytes
);

  // ----------------------------------------------------------------
  // helper functions
  // shared decode and arithmetic; the decode loop and the read mux both
  // call code_base and exp_mask, so base and mask read back exactly as they are matched
  // ----------------------------------------------------------------
  // byte count for burst and stop codes: 8 << code
  // 8 << 3 = 64 still fits the seven-bit result
  function [6:0] code_bytes;
    input [1:0] code;
    begin
      code_bytes = `SVM_BYTES_BASE << code;
    end
  endfunction

  // window size mask from a compare code exponent (size = 2**exp)
  // an exponent of zero gives an empty mask, a one-byte window
  function [AW-1:0] exp_mask;
    input [4:0] e;
    begin
      exp_mask = ~({AW{1'b1}} << e);
    end
  endfunction

  // window base from a compare code, aligned down to its size
  // the base field counts 16-byte units, so a window of up to 16 bytes can sit on any such step
  function [AW-1:0] code_base;
    input [31:0] c;
    begin
      code_base = ({{(AW-24){1'b0}}, c[`SVM_CODE_BASE_HI:`SVM_CODE_BASE_LO]}
                   << `SVM_CODE_BASE_SHIFT)
                  & ~exp_mask(c[`SVM_CODE_EXP_HI:`SVM_CODE_EXP_LO]);
    end
  endfunction

  // transfer size allowed by a data width code
  // block and multiplexed widths belong to block moves, which this single-cycle
  // path does not generate, so they refuse like reserved codes
  function size_ok;
    input [2:0] dw;
    input [1:0] sz;
    begin
      case (dw)
        `SVM_DW_WORD:     size_ok = (sz == `SVM_SZ_BYTE) || (sz == `SVM_SZ_HALF)
                                    || (sz == `SVM_SZ_WORD);
        `SVM_DW_HALFWORD: size_ok = (sz == `SVM_SZ_BYTE) || (sz == `SVM_SZ_HALF);
        `SVM_DW_BYTE:     size_ok = (sz == `SVM_SZ_BYTE);
        default:          size_ok = 1'b0;
      endcase
    end
  endfunction

  // address space code valid for single cycles
  // the 64-bit space needs a multiplexed address phase that single cycles lack,
  // so it refuses together with the reserved codes
  function space_ok;
    input [2:0] as;
    begin
      case (as)
        `SVM_AS_SHORT, `SVM_AS_STANDARD, `SVM_AS_EXTENDED: space_ok = 1'b1;
        default: space_ok = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // range register sets
  // ----------------------------------------------------------------
  // every range keeps four words: vme base, compare code, capabilities and
  // the enable bit; window base and mask are derived on read, so the
  // compare code is the single place where a window is stored
  reg [31:0] vme_base_mem [0:NRANGE-1];
  reg [31:0] sb_code_mem  [0:NRANGE-1];
  reg [6:0]  cap_mem      [0:NRANGE-1];
  reg        ena_mem      [0:NRANGE-1];
  // global settings and last-request status
  reg [1:0]  burst_reg;
  reg [1:0]  stop_reg;
  reg [1:0]  burst_next;
  reg [1:0]  stop_next;
  reg        hit_reg;
  reg        miss_reg;

  // register bus address split into range index, register and global select
  wire [3:0] rsel     = reg_addr[`SVM_RANGE_SEL_HI:`SVM_RANGE_SEL_LO];
  wire [3:0] rreg     = reg_addr[`SVM_REG_SEL_HI:`SVM_REG_SEL_LO];
  wire       rglobal  = reg_addr[`SVM_GLOBAL_BIT];
  integer    i;

  // next values of the two-bit settings: upper written bits dropped
  // a write with any upper bits set still lands, only the low two count
  always @* begin
    burst_next = burst_reg;
    stop_next  = stop_reg;
    if (reg_wr && rglobal && rreg == `SVM_REG_BURST_LEN)
      burst_next = reg_wdata[`SVM_CODE2_HI:`SVM_CODE2_LO];
    if (reg_wr && rglobal && rreg == `SVM_REG_READ_STOP)
      stop_next = reg_wdata[`SVM_CODE2_HI:`SVM_CODE2_LO];
  end

  // ----------------------------------------------------------------
  // register write path
  // ----------------------------------------------------------------
  // register writes; a low clock enable holds every stored field
  // nothing here blocks a rewrite of a live range, so a request in the
  // same cycle may see a mix of old and new fields; software therefore
  // disables a range before it changes that range's register set
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < NRANGE; i = i + 1) begin
        vme_base_mem[i] <= 32'h0000_0000;
        sb_code_mem[i]  <= 32'h0000_0000;
        cap_mem[i]      <= 7'h00;
        ena_mem[i]      <= 1'b0;
      end
      burst_reg <= `SVM_RESET_CODE2;
      stop_reg  <= `SVM_RESET_CODE2;
    end else if (clk_en) begin
      burst_reg <= burst_next;
      stop_reg  <= stop_next;
      if (reg_wr && !rglobal) begin
        case (rreg)
          `SVM_REG_VME_BASE: vme_base_mem[rsel] <= reg_wdata;
          `SVM_REG_SB_CODE:  sb_code_mem[rsel]  <= reg_wdata;
          `SVM_REG_CAP:      cap_mem[rsel]      <= reg_wdata[`SVM_CAP_AS_HI:`SVM_CAP_DW_LO];
          `SVM_REG_ENA:      ena_mem[rsel]      <= reg_wdata[`SVM_ENA_BIT];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------
  // register read mux, data one cycle after the strobe
  // the data word returns to zero in every other enabled cycle, so a late sample
  // by the master reads zero rather than a stale word
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd && rglobal) begin
        case (rreg)
          `SVM_REG_BURST_LEN: reg_rdata <= {30'h0000_0000, burst_reg};
          `SVM_REG_READ_STOP: reg_rdata <= {30'h0000_0000, stop_reg};
          `SVM_REG_STATUS:    reg_rdata <= {30'h0000_0000, miss_reg, hit_reg};
          default:            reg_rdata <= 32'h0000_0000;
        endcase
      end else if (reg_rd) begin
        case (rreg)
          `SVM_REG_VME_BASE: reg_rdata <= vme_base_mem[rsel];
          `SVM_REG_SB_CODE:  reg_rdata <= sb_code_mem[rsel];
          `SVM_REG_CAP:      reg_rdata <= {25'h000_0000, cap_mem[rsel]};
          `SVM_REG_ENA:      reg_rdata <= {31'h0000_0000, ena_mem[rsel]};
          // compare code decoded back into base and size mask
          `SVM_REG_WIN_BASE: reg_rdata <= code_base(sb_code_mem[rsel]);
          `SVM_REG_WIN_MASK: reg_rdata <= exp_mask(
                               sb_code_mem[rsel][`SVM_CODE_EXP_HI:`SVM_CODE_EXP_LO]);
          default:           reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // window decode and translation
  // ----------------------------------------------------------------
  // combinational decode results, valid in the cycle of the request
  reg          hit;
  reg [AW-1:0] xlat;
  reg [2:0]    space;
  reg [31:0]   c;
  reg [AW-1:0] m;
  integer      k;

  // lowest numbered matching enabled range wins
  // the loop runs from the top index down so that the last assignment,
  // which is the lowest index, decides on overlap; exponents above
  // SVM_EXP_MAX (28) never match, so a bad code cannot open the whole space
  always @* begin
    hit   = 1'b0;
    xlat  = {AW{1'b0}};
    space = `SVM_AS_SHORT;
    c     = 32'h0000_0000;
    m     = {AW{1'b0}};
    for (k = NRANGE - 1; k >= 0; k = k - 1) begin
      c = sb_code_mem[k];
      m = exp_mask(c[`SVM_CODE_EXP_HI:`SVM_CODE_EXP_LO]);
      if (ena_mem[k]
          && c[`SVM_CODE_EXP_HI:`SVM_CODE_EXP_LO] <= `SVM_EXP_MAX
          && sb_slot == c[`SVM_CODE_SLOT_HI:`SVM_CODE_SLOT_LO]
          && (sb_addr & ~m) == code_base(c)
          && space_ok(cap_mem[k][`SVM_CAP_AS_HI:`SVM_CAP_AS_LO])
          && size_ok(cap_mem[k][`SVM_CAP_DW_HI:`SVM_CAP_DW_LO], sb_size)) begin
        hit   = 1'b1;
        xlat  = vme_base_mem[k] + (sb_addr & m);
        space = cap_mem[k][`SVM_CAP_AS_HI:`SVM_CAP_AS_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // vme cycle output
  // ----------------------------------------------------------------
  // vme cycle start pulse and sticky status
  // address, space, size and direction change only on a hit, so the
  // far side sees stable cycle fields between starts
  // the status pair records the outcome of the most recent request
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vme_start <= 1'b0;
      vme_addr  <= {AW{1'b0}};
      vme_space <= `SVM_AS_SHORT;
      vme_size  <= `SVM_SZ_BYTE;
      vme_write <= 1'b0;
      sb_reject <= 1'b0;
      hit_reg   <= 1'b0;
      miss_reg  <= 1'b0;
    end else if (clk_en) begin
      vme_start <= sb_req && hit;
      sb_reject <= sb_req && !hit;
      // cycle fields load only on a hit
      if (sb_req && hit) begin
        vme_addr  <= xlat;
        vme_space <= space;
        vme_size  <= sb_size;
        vme_write <= sb_write;
      end
      hit_reg  <= sb_req ? hit : hit_reg;
      miss_reg <= sb_req ? !hit : miss_reg;
    end
  end

  // ----------------------------------------------------------------
  // burst and read stop outputs
  // ----------------------------------------------------------------
  // burst and read stop limits in bytes
  // these follow the next-value codes so that they move at the same edge
  // as the stored settings and never lag a write by a cycle
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      burst_len_code  <= `SVM_RESET_CODE2;
      burst_len_bytes <= `SVM_BYTES_BASE;
      read_stop_bytes <= `SVM_BYTES_BASE;
    end else if (clk_en) begin
      burst_len_code  <= burst_next;
      burst_len_bytes <= code_bytes(burst_next);
      read_stop_bytes <= code_bytes(stop_next);
    end
  end

endmodule

//--- sim/svm_bridge_chk.sv
// assertion checker for the sbus to vme master window bridge
`timescale 1ns/1ps
module svm_bridge_chk #(
  parameter NRANGE = 16,
  parameter AW     = 32
) (
  input wire          sys_clk,
  input wire          nrst,
  input wire          clk_en,
  input wire [8:0]    reg_addr,
  input wire [31:0]   reg_wdata,
  input wire          reg_wr,
  input wire          sb_req,
  input wire [1:0]    sb_size,
  input wire          sb_write,
  input wire          vme_start,
  input wire [AW-1:0] vme_addr,
  input wire [2:0]    vme_space,
  input wire [1:0]    vme_size,
  input wire          vme_write,
  input wire          sb_reject,
  input wire [1:0]    burst_len_code,
  input wire [6:0]    burst_len_bytes,
  input wire [6:0]    read_stop_bytes
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // qualified request and the two low bits of a register write
  wire       req_ok = sb_req && clk_en;
  wire       set_wr = reg_wr && clk_en;
  wire [1:0] wr_low = reg_wdata[1:0];
  answer_once_a: assert property (req_ok |=> vme_start ^ sb_reject)
    else $error("request not answered by exactly one of start or reject");
  no_cause_a: assert property (!req_ok |=> !vme_start && !sb_reject)
    else $error("start or reject without a request");
  size_kept_a: assert property (vme_start |-> vme_size == $past(sb_size)
    && vme_write == $past(sb_write)) else $error("vme size or direction not taken from request");
  space_legal_a: assert property (vme_start |-> vme_space <= 3'h2)
    else $error("vme cycle in a reserved address space");
  addr_hold_a: assert property (!vme_start |-> $stable(vme_addr))
    else $error("vme address moved without a new cycle");
  bad_size_a: assert property (req_ok && sb_size == 2'h3 |=> sb_reject)
    else $error("invalid access size was not refused");
  burst_map_a: assert property (burst_len_bytes == (7'h08 << burst_len_code))
    else $error("burst byte count does not match its code");
  burst_low_a: assert property (set_wr && reg_addr == 9'h100
    |=> burst_len_code == $past(wr_low)) else $error("burst code not the two low written bits");
  stop_low_a: assert property (set_wr && reg_addr == 9'h101
    |=> read_stop_bytes == (7'h08 << $past(wr_low))) else $error("read stop bytes wrong");
  start_c: cover property (vme_start);
  reject_c: cover property (sb_reject);
  burst_c: cover property (set_wr && reg_addr == 9'h100);
endmodule
bind svm_bridge svm_bridge_chk #(.NRANGE(NRANGE), .AW(AW)) chk_i (
  .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .sb_req(sb_req), .sb_size(sb_size),
  .sb_write(sb_write), .vme_start(vme_start), .vme_addr(vme_addr),
  .vme_space(vme_space), .vme_size(vme_size), .vme_write(vme_write),
  .sb_reject(sb_reject), .burst_len_code(burst_len_code),
  .burst_len_bytes(burst_len_bytes), .read_stop_bytes(read_stop_bytes));

//--- sim/svm_vme_model.sv
// vme slave side stand-in: logs every cycle the bridge starts
`timescale 1ns/1ps
module svm_vme_model (
  input  wire         sys_clk,
  input  wire         nrst,
  input  wire         vme_start,
  input  wire  [31:0] vme_addr,
  output logic [15:0] seen_count,
  output logic [31:0] seen_addr
);
  // count started cycles and keep the address of the latest one
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seen_count <= 16'h0000;
      seen_addr  <= 32'h0000_0000;
    end else if (vme_start) begin
      seen_count <= seen_count + 16'h0001;
      seen_addr  <= vme_addr;
    end
  end
endmodule

//--- sim/test_svm_bridge.sv
// self-checking bench for the sbus to vme master window bridge
`timescale 1ns/1ps
module test_svm_bridge;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_en = 1'b1;
  logic [8:0]  reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        sb_req = 1'b0;
  logic [2:0]  sb_slot = 3'h0;
  logic [31:0] sb_addr = 32'h0000_0000;
  logic [1:0]  sb_size = 2'h0;
  logic        sb_write = 1'b0;
  wire  [31:0] reg_rdata, vme_addr, seen_addr;
  wire  [15:0] seen_count;
  wire  [6:0]  burst_len_bytes, read_stop_bytes;
  wire  [2:0]  vme_space;
  wire  [1:0]  vme_size, burst_len_code;
  wire         vme_start, vme_write, sb_reject;
  int          err_total = 0;
  int          n_checks = 0;
  int          cycles = 0;
  svm_bridge uut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sb_req(sb_req), .sb_slot(sb_slot), .sb_addr(sb_addr), .sb_size(sb_size),
    .sb_write(sb_write), .vme_start(vme_start), .vme_addr(vme_addr), .vme_space(vme_space),
    .vme_size(vme_size), .vme_write(vme_write), .sb_reject(sb_reject),
    .burst_len_code(burst_len_code), .burst_len_bytes(burst_len_bytes),
    .read_stop_bytes(read_stop_bytes));
  svm_vme_model model (.sys_clk(sys_clk), .nrst(nrst), .vme_start(vme_start),
    .vme_addr(vme_addr), .seen_count(seen_count), .seen_addr(seen_addr));
  // clock and hang guard
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge sys_clk);
    #1 chk(reg_rdata, 32'h0000_0000);
  endtask
  // one request; expect a start at ea in space es, or a refusal
  task automatic req(input logic [2:0] s, input logic [31:0] a, input logic [1:0] z,
                     input logic go, input logic [31:0] ea, input logic [2:0] es);
    logic [15:0] n0;
    n0 = seen_count;
    @(posedge sys_clk);
    sb_req <= 1'b1;
    sb_slot <= s;
    sb_addr <= a;
    sb_size <= z;
    sb_write <= a[4];
    @(posedge sys_clk);
    sb_req <= 1'b0;
    #1 chk({31'h0, vme_start}, {31'h0, go});
    chk({31'h0, sb_reject}, {31'h0, !go});
    @(posedge sys_clk);
    #1 chk({16'h0, seen_count}, {16'h0, n0 + {15'h0, go}});
    if (go) begin
      chk(seen_addr, ea);
      chk({29'h0, vme_space}, {29'h0, es});
      chk({30'h0, vme_size}, {30'h0, z});
      chk({31'h0, vme_write}, {31'h0, a[4]});
    end
  endtask
  task automatic t_regs;
    chk({25'h0, burst_len_bytes}, 32'h0000_0008);
    chk({25'h0, read_stop_bytes}, 32'h0000_0008);
    rd(9'h1FF, 32'h0000_0000);
    rd(9'h003, 32'h0000_0000);
  endtask
  task automatic t_settings;
    for (int i = 0; i < 4; i++) begin
      wr(9'h100, 32'hFFFF_FFF0 | i);
      wr(9'h101, 32'hABCD_EF00 | (3 - i));
      #1 chk({30'h0, burst_len_code}, i);
      chk({25'h0, burst_len_bytes}, 32'h0000_0008 << i);
      rd(9'h100, i);
      rd(9'h101, 3 - i);
      chk({25'h0, read_stop_bytes}, 32'h0000_0008 << (3 - i));
    end
  endtask
  task automatic t_word;
    wr(9'h000, 32'h4080_0000);
    wr(9'h001, 32'h350A_0000);
    wr(9'h002, 32'h0000_0022);
    req(3'h1, 32'h00A0_0010, 2'h2, 1'b0, '0, '0);
    wr(9'h003, 32'h0000_0001);
    rd(9'h001, 32'h350A_0000);
    rd(9'h004, 32'h00A0_0000);
    rd(9'h005, 32'h001F_FFFF);
    for (int z = 0; z < 3; z++)
      req(3'h1, 32'h00A0_0010, z[1:0], 1'b1, 32'h4080_0010, 3'h2);
    req(3'h1, 32'h00BF_FFFC, 2'h2, 1'b1, 32'h409F_FFFC, 3'h2);
    req(3'h1, 32'h00C0_0000, 2'h2, 1'b0, '0, '0);
    req(3'h2, 32'h00A0_0010, 2'h2, 1'b0, '0, '0);
    rd(9'h102, 32'h0000_0002);
  endtask
  task automatic t_half;
    wr(9'h010, 32'h0098_0000);
    wr(9'h011, 32'h3312_0000);
    wr(9'h012, 32'h0000_0011);
    wr(9'h013, 32'h0000_0001);
    req(3'h1, 32'h0127_FFFE, 2'h1, 1'b1, 32'h009F_FFFE, 3'h1);
    req(3'h1, 32'h0120_0001, 2'h0, 1'b1, 32'h0098_0001, 3'h1);
    rd(9'h102, 32'h0000_0001);
    req(3'h1, 32'h0127_FFFC, 2'h2, 1'b0, '0, '0);
  endtask
  task automatic t_byte;
    wr(9'h0F0, 32'h0000_0000);
    wr(9'h0F1, 32'h7040_0000);
    wr(9'h0F2, 32'h0000_0000);
    wr(9'h0F3, 32'h0000_0001);
    rd(9'h0F1, 32'h7040_0000);
    req(3'h3, 32'h0400_FFFF, 2'h0, 1'b1, 32'h0000_FFFF, 3'h0);
    req(3'h3, 32'h0400_0010, 2'h1, 1'b0, '0, '0);
    req(3'h3, 32'h0400_0010, 2'h3, 1'b0, '0, '0);
  endtask
  task automatic t_reserved;
    for (int k = 3; k < 8; k++) begin
      wr(9'h0F3, 32'h0000_0000);
      wr(9'h0F2, {25'h0, k[2:0], 4'h0});
      wr(9'h0F3, 32'h0000_0001);
      req(3'h3, 32'h0400_0001, 2'h0, 1'b0, '0, '0);
      wr(9'h0F3, 32'h0000_0000);
      wr(9'h0F2, {29'h0, k[2:0]});
      wr(9'h0F3, 32'h0000_0001);
      req(3'h3, 32'h0400_0001, 2'h0, 1'b0, '0, '0);
    end
    wr(9'h0F3, 32'h0000_0000);
    wr(9'h0F2, 32'h0000_0000);
    req(3'h3, 32'h0400_0001, 2'h0, 1'b0, '0, '0);
  endtask
  // clock enable low: a write and a request in that cycle leave no trace
  task automatic t_freeze;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= 9'h100;
    reg_wdata <= 32'h0000_0000;
    sb_req <= 1'b1;
    sb_slot <= 3'h1;
    sb_addr <= 32'h00A0_0010;
    sb_size <= 2'h2;
    @(posedge sys_clk);
    clk_en <= 1'b1;
    reg_wr <= 1'b0;
    sb_req <= 1'b0;
    #1 chk({31'h0, vme_start}, 32'h0000_0000);
    chk({31'h0, sb_reject}, 32'h0000_0000);
    chk({30'h0, burst_len_code}, 32'h0000_0003);
  endtask
  // reset in mid-run: settings and ranges fall back to their reset state
  task automatic t_rerun;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk({25'h0, burst_len_bytes}, 32'h0000_0008);
    chk({25'h0, read_stop_bytes}, 32'h0000_0008);
    chk(vme_addr, 32'h0000_0000);
    @(posedge sys_clk);
    nrst <= 1'b1;
    rd(9'h003, 32'h0000_0000);
    req(3'h1, 32'h00A0_0010, 2'h2, 1'b0, '0, '0);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_settings;
    t_word;
    t_freeze;
    t_half;
    t_byte;
    t_reserved;
    t_rerun;
    print_verdict;
  end
endmodule
